// ==== design/ipl_defs.svh ====
// Purpose: Offsets, field positions, reset values of the priority registers
// Assumes: Word addressed register port, one register per address
// Notes: Overview of the numbered behaviour follows
//
// Overview of operation
// [RULE_01] Crossbar field is register one bits 3:2; 00 off, 01-11 levels 1-3
// [RULE_02] Register one sources use levels one to three, reset to disabled
// [RULE_03] Register two sits at word offset two, sixteen bits, resets to zero
// [RULE_04] Register two bits 15:14 are reserved with no priority meaning
// [RULE_05] Register two fields: 00 off, 01-11 levels 0-2, reset to off
// [RULE_06] Bits 13:12 set cyclic converter limit or zero-crossing level
// [RULE_07] Bits 11:10 set conversion-complete level except B parallel scan
// [RULE_08] Bits 9:8 set converter B parallel scan conversion-complete level
// [RULE_09] Timer channels 0..3 occupy bits 7:6, 5:4, 3:2, 1:0
// [RULE_10] Register one sits at word offset one, just below register two
// [RULE_11] Reserved bits of both registers read zero and ignore writes
`ifndef IPL_DEFS_SVH
`define IPL_DEFS_SVH

`define IPL_ADDR_W 8
`define IPL_DATA_W 16
`define IPL_IDX_REG_ONE 8'h01
`define IPL_IDX_REG_TWO 8'h02
`define IPL_RST_REG_ONE 16'h0000
`define IPL_RST_REG_TWO 16'h0000
`define IPL_RST_CODE 2'h0
`define IPL_CODE_OFF 2'h0
`define IPL_FIELD_W 2
`define IPL_NUM_PERIPH 7
`define IPL_POS_XBAR 2
`define IPL_POS_CONV_LIMIT 12
`define IPL_POS_CONV_MAIN 10
`define IPL_POS_CONV_B 8
`define IPL_POS_TMR0 6
`define IPL_POS_TMR1 4
`define IPL_POS_TMR2 2
`define IPL_POS_TMR3 0
`define IPL_MASK_REG_ONE 16'h000C
`define IPL_MASK_REG_TWO 16'h3FFF

`endif

// ==== design/ipl_level_decode.sv ====
// Purpose: Turns stored two-bit codes into enable and arbitration level
// Assumes: Codes come straight from flip-flops
// Notes: Register one sources use levels 1-3, register two sources 0-2
`timescale 1ns/1ps
`include "ipl_defs.svh"
module ipl_level_decode (
    input wire logic clock,
    input wire logic reset,
    ipl_prio_if.decoder prio
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    // Disabled sources report level zero so the arbiter sees a clean value
    function automatic ipl_pkg::ipl_dec_t decodeCode(
        input ipl_pkg::ipl_code_t code,
        input logic upperBank
    );
        ipl_pkg::ipl_dec_t d;
        d.enable = (code != `IPL_CODE_OFF);
        d.level = 2'h0;
        if (d.enable) begin
            d.level = upperBank ? code : 2'(code - 2'h1);
        end
        return d;
    endfunction

    ipl_pkg::ipl_dec_t xbarDec;

    assign xbarDec = decodeCode(prio.xbarCode, 1'h1); // [RULE_01] [RULE_02]
    assign prio.xbarEnable = xbarDec.enable;
    assign prio.xbarLevel = xbarDec.level;

    genvar gi;
    generate
        for (gi = 0; gi < `IPL_NUM_PERIPH; gi++) begin : g_periph
            ipl_pkg::ipl_dec_t pd;
            assign pd = decodeCode(prio.periphCode[gi], 1'h0); // [RULE_05]
            assign prio.periphEnable[gi] = pd.enable;
            assign prio.periphLevel[gi] = pd.level;
        end
    endgenerate

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_xbar_decode;
        @(posedge clock) disable iff (reset)
        (prio.xbarCode != 2'h0) |->
            (prio.xbarEnable && prio.xbarLevel == prio.xbarCode);
    endproperty
    a_xbar_decode: assert property (p_xbar_decode) // [RULE_01]
        else $error("crossbar level not equal to code");

    property p_periph_decode;
        @(posedge clock) disable iff (reset)
        (prio.periphCode[6] == 2'h3) |->
            (prio.periphEnable[6] && prio.periphLevel[6] == 2'h2);
    endproperty
    a_periph_decode: assert property (p_periph_decode) // [RULE_05]
        else $error("code 11 did not decode to level 2");

    property p_periph_off;
        @(posedge clock) disable iff (reset)
        (prio.periphCode[0] == 2'h0) |-> !prio.periphEnable[0];
    endproperty
    a_periph_off: assert property (p_periph_off) // [RULE_05]
        else $error("code 00 left source enabled");

endmodule

// ==== design/ipl_pkg.sv ====
// Purpose: Types shared by the priority register block
// Assumes: Two-bit priority codes
// Notes: Peripheral field i sits at register two bits 2i+1:2i
package ipl_pkg;

    typedef logic [1:0] ipl_code_t;

    typedef ipl_code_t [6:0] ipl_periph_t;

    typedef struct packed {
        logic enable;
        logic [1:0] level;
    } ipl_dec_t;

    typedef struct packed {
        ipl_code_t xbar;
        ipl_periph_t periph;
        logic [15:0] readData;
    } ipl_state_t;

endpackage

// ==== design/ipl_prio_if.sv ====
// Purpose: Carries stored codes to the decoder and decoded levels back
// Assumes: Single clock domain, purely combinational return path
// Notes: None
`timescale 1ns/1ps
interface ipl_prio_if;
    ipl_pkg::ipl_code_t xbarCode;
    ipl_pkg::ipl_periph_t periphCode;
    logic xbarEnable;
    logic [1:0] xbarLevel;
    logic [6:0] periphEnable;
    logic [6:0][1:0] periphLevel;

    modport regs (
        output xbarCode,
        output periphCode,
        input xbarEnable,
        input xbarLevel,
        input periphEnable,
        input periphLevel
    );

    modport decoder (
        input xbarCode,
        input periphCode,
        output xbarEnable,
        output xbarLevel,
        output periphEnable,
        output periphLevel
    );
endinterface

// ==== design/ipl_priority_regs.sv ====
// Purpose: Priority level registers for crossbar, converter and timer IRQs
// Assumes: One-cycle strobes, never both at once; read data next cycle
// Notes: Unmapped addresses read zero and ignore writes
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "ipl_defs.svh"
module ipl_priority_regs (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic [15:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [15:0] readData,
    output logic [1:0] crossbarRequestPrio,
    output logic [1:0] cyclicConverterLimitPrio,
    output logic [1:0] convDoneMainPrio,
    output logic [1:0] convDoneBParallelPrio,
    output logic [1:0] timerCh0Prio,
    output logic [1:0] timerCh1Prio,
    output logic [1:0] timerCh2Prio,
    output logic [1:0] timerCh3Prio,
    output logic crossbarEnable,
    output logic [1:0] crossbarLevel,
    output logic [6:0] periphEnable,
    output logic [13:0] periphLevel
);

    // ****************************************************************
    // State
    // ****************************************************************
    ipl_pkg::ipl_state_t state_reg;
    ipl_pkg::ipl_state_t state_next;

    // Full images as software sees them, reserved bits forced low
    function automatic logic [15:0] imageOne(input ipl_pkg::ipl_code_t x);
        logic [15:0] v;
        v = 16'h0000;
        v[`IPL_POS_XBAR +: `IPL_FIELD_W] = x; // [RULE_01]
        return v & `IPL_MASK_REG_ONE; // [RULE_11]
    endfunction

    function automatic logic [15:0] imageTwo(input ipl_pkg::ipl_periph_t p);
        logic [15:0] v;
        v = {2'h0, p}; // [RULE_04]
        return v & `IPL_MASK_REG_TWO; // [RULE_11]
    endfunction

    function automatic logic hitOne(input logic [7:0] a);
        return a == `IPL_IDX_REG_ONE; // [RULE_10]
    endfunction

    function automatic logic hitTwo(input logic [7:0] a);
        return a == `IPL_IDX_REG_TWO; // [RULE_03]
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        // Read data stands only in the cycle after the read strobe
        state_next.readData = 16'h0000;
        if (writeStrobe) begin
            if (hitOne(address)) begin
                // Only bits 3:2 are stored; the rest are dropped
                state_next.xbar =
                    writeData[`IPL_POS_XBAR +: `IPL_FIELD_W]; // [RULE_11]
            end
            if (hitTwo(address)) begin
                // Bits 15:14 are never stored
                state_next.periph =
                    writeData[13:0]; // [RULE_04] [RULE_06] [RULE_07]
            end
        end
        if (readStrobe) begin
            if (hitOne(address)) begin
                state_next.readData = imageOne(state_reg.xbar);
            end else if (hitTwo(address)) begin
                state_next.readData = imageTwo(state_reg.periph);
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg.xbar <= `IPL_RST_CODE; // [RULE_02]
            // All register two fields come up disabled
            state_reg.periph <= 14'(`IPL_RST_REG_TWO); // [RULE_03] [RULE_05]
            state_reg.readData <= 16'h0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign readData = state_reg.readData;
    assign crossbarRequestPrio = state_reg.xbar;
    assign cyclicConverterLimitPrio = state_reg.periph[6]; // [RULE_06]
    assign convDoneMainPrio = state_reg.periph[5]; // [RULE_07]
    assign convDoneBParallelPrio = state_reg.periph[4]; // [RULE_08]
    assign timerCh0Prio = state_reg.periph[3]; // [RULE_09]
    assign timerCh1Prio = state_reg.periph[2]; // [RULE_09]
    assign timerCh2Prio = state_reg.periph[1]; // [RULE_09]
    assign timerCh3Prio = state_reg.periph[0]; // [RULE_09]

    ipl_prio_if prio ();

    assign prio.xbarCode = state_reg.xbar;
    assign prio.periphCode = state_reg.periph;

    ipl_level_decode u_decode (
        .clock(clock),
        .reset(reset),
        .prio(prio)
    );

    assign crossbarEnable = prio.xbarEnable;
    assign crossbarLevel = prio.xbarLevel;
    assign periphEnable = prio.periphEnable;
    assign periphLevel = prio.periphLevel;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [15:0] twoImage;
    logic [15:0] oneImage;

    assign twoImage = imageTwo(state_reg.periph);
    assign oneImage = imageOne(state_reg.xbar);

    sequence s_write_one;
        writeStrobe && address == `IPL_IDX_REG_ONE;
    endsequence

    sequence s_write_two;
        writeStrobe && address == `IPL_IDX_REG_TWO;
    endsequence

    sequence s_read_two;
        readStrobe && address == `IPL_IDX_REG_TWO;
    endsequence

    sequence s_read_one;
        readStrobe && address == `IPL_IDX_REG_ONE;
    endsequence

    property p_reset_off;
        @(posedge clock)
        reset |=> (crossbarRequestPrio == 2'h0 && twoImage == 16'h0000);
    endproperty
    a_reset_off: assert property (p_reset_off) // [RULE_02] [RULE_03]
        else $error("fields not disabled after reset");

    property p_write_one;
        @(posedge clock) disable iff (reset)
        s_write_one |=> crossbarRequestPrio == $past(writeData[3:2]);
    endproperty
    a_write_one: assert property (p_write_one) // [RULE_01] [RULE_10]
        else $error("crossbar field not written from bits 3:2");

    property p_write_two;
        @(posedge clock) disable iff (reset)
        s_write_two |=> (cyclicConverterLimitPrio == $past(writeData[13:12])
            && convDoneMainPrio == $past(writeData[11:10])
            && convDoneBParallelPrio == $past(writeData[9:8])
            && timerCh0Prio == $past(writeData[7:6])
            && timerCh3Prio == $past(writeData[1:0]));
    endproperty
    a_write_two: assert property (p_write_two) // [RULE_06] [RULE_09]
        else $error("register two field misplaced");

    property p_readback_two;
        @(posedge clock) disable iff (reset)
        s_write_two ##1 s_read_two |=>
            readData == ($past(writeData, 2) & 16'h3FFF);
    endproperty
    a_readback_two: assert property (p_readback_two) // [RULE_04]
        else $error("register two readback wrong or reserved bits set");

    property p_read_one;
        @(posedge clock) disable iff (reset)
        s_read_one |=> (readData == $past(oneImage)
            && (readData & 16'hFFF3) == 16'h0000);
    endproperty
    a_read_one: assert property (p_read_one) // [RULE_11]
        else $error("register one reserved bits not zero");

    property p_idle_zero;
        @(posedge clock) disable iff (reset)
        !readStrobe |=> readData == 16'h0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) // [RULE_11]
        else $error("read data outside read slot");

    property p_hold_two;
        @(posedge clock) disable iff (reset)
        !(writeStrobe && address == `IPL_IDX_REG_TWO) |=> $stable(twoImage);
    endproperty
    a_hold_two: assert property (p_hold_two) // [RULE_03]
        else $error("register two changed without a write");

    property p_hold_one;
        @(posedge clock) disable iff (reset)
        !(writeStrobe && address == `IPL_IDX_REG_ONE) |=>
            $stable(crossbarRequestPrio);
    endproperty
    a_hold_one: assert property (p_hold_one) // [RULE_10]
        else $error("register one changed without a write");

    property p_xbar_level;
        @(posedge clock) disable iff (reset)
        s_write_one ##1 (crossbarRequestPrio == 2'h1) |->
            (crossbarEnable && crossbarLevel == 2'h1);
    endproperty
    a_xbar_level: assert property (p_xbar_level) // [RULE_01] [RULE_02]
        else $error("crossbar code 01 not level 1");

    property p_conv_b_level;
        @(posedge clock) disable iff (reset)
        (convDoneBParallelPrio == 2'h1) |->
            (periphEnable[4] && periphLevel[9:8] == 2'h0);
    endproperty
    a_conv_b_level: assert property (p_conv_b_level) // [RULE_08] [RULE_05]
        else $error("converter B code 01 not level 0");

endmodule

// ==== verification/ipl_core_model.sv ====
// Purpose: Processor core side of the priority register port
// Assumes: Tasks are entered just after a rising clock edge
// Notes: A write leaves its strobe up; the next read or idle lowers it
`timescale 1ns/1ps
module ipl_core_model (
    input wire logic clock,
    output logic [7:0] address,
    output logic [15:0] writeData,
    output logic writeStrobe,
    output logic readStrobe,
    input wire logic [15:0] readData
);
    initial begin
        address = 8'h00;
        writeData = 16'h0000;
        writeStrobe = 1'h0;
        readStrobe = 1'h0;
    end

    // ************************************************
    // Bus cycles
    // ************************************************
    // Each signal changes at most once per edge, so calls chain freely
    task automatic writeWord(input logic [7:0] addr, input logic [15:0] data);
        address <= addr;
        writeData <= data;
        writeStrobe <= 1'h1;
        readStrobe <= 1'h0;
        @(posedge clock);
    endtask

    // Data is taken at the edge that ends its one-cycle slot
    task automatic readWord(input logic [7:0] addr, output logic [15:0] data);
        address <= addr;
        readStrobe <= 1'h1;
        writeStrobe <= 1'h0;
        @(posedge clock);
        readStrobe <= 1'h0;
        @(posedge clock);
        data = readData;
    endtask

    task automatic idle();
        writeStrobe <= 1'h0;
        readStrobe <= 1'h0;
        @(posedge clock);
    endtask
endmodule

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the priority level registers
// Assumes: 40 MHz clock, asynchronous active high reset
// Notes: Expected images are shadowed here, never read from the design
`timescale 1ns/1ps
`include "ipl_defs.svh"
module tb;
    typedef struct {
        logic [7:0] addr;
        logic [15:0] wr;
        logic [15:0] rd;
    } ipl_row_t;

    logic clock;
    logic reset;
    logic [7:0] address;
    logic [15:0] writeData;
    logic writeStrobe;
    logic readStrobe;
    logic [15:0] readData;
    logic [1:0] xbarPrio, limPrio, mainPrio, bPrio, t0, t1, t2, t3;
    logic crossbarEnable;
    logic [1:0] crossbarLevel;
    logic [6:0] periphEnable;
    logic [13:0] periphLevel;
    logic [15:0] regOneExp, regTwoExp, got;
    int badCount = 0;
    int checkCount = 0;
    int cycleCount = 0;

    // Unmapped rows keep both shadows unchanged
    ipl_row_t rows [12] = '{
        '{`IPL_IDX_REG_TWO, 16'hFFFF, 16'h3FFF},
        '{`IPL_IDX_REG_TWO, 16'h5555, 16'h1555},
        '{`IPL_IDX_REG_TWO, 16'hAAAA, 16'h2AAA},
        '{`IPL_IDX_REG_TWO, 16'h1B6C, 16'h1B6C},
        '{`IPL_IDX_REG_TWO, 16'hC000, 16'h0000},
        '{`IPL_IDX_REG_ONE, 16'hFFFF, 16'h000C},
        '{`IPL_IDX_REG_ONE, 16'h0004, 16'h0004},
        '{`IPL_IDX_REG_ONE, 16'h0008, 16'h0008},
        '{8'h03, 16'hFFFF, 16'h0000},
        '{8'h00, 16'hFFFF, 16'h0000},
        '{8'hFF, 16'hFFFF, 16'h0000},
        '{`IPL_IDX_REG_ONE, 16'hFFF3, 16'h0000}
    };

    ipl_priority_regs i_ipl_priority_regs (
        .clock(clock), .reset(reset), .address(address),
        .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData),
        .crossbarRequestPrio(xbarPrio), .cyclicConverterLimitPrio(limPrio),
        .convDoneMainPrio(mainPrio), .convDoneBParallelPrio(bPrio),
        .timerCh0Prio(t0), .timerCh1Prio(t1), .timerCh2Prio(t2),
        .timerCh3Prio(t3), .crossbarEnable(crossbarEnable),
        .crossbarLevel(crossbarLevel), .periphEnable(periphEnable),
        .periphLevel(periphLevel)
    );

    ipl_core_model m_core (
        .clock(clock), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe),
        .readData(readData)
    );

    // ************************************************
    // Checking helpers
    // ************************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic checkVal(input string name, input logic [15:0] exp,
                            input logic [15:0] seen);
        checkCount++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            badCount++;
        end
    endtask

    function automatic logic [1:0] periphLvl(input logic [1:0] c);
        return (c == 2'h0) ? 2'h0 : c - 2'h1;
    endfunction

    task automatic checkOutputs();
        logic [6:0] enExp;
        logic [13:0] lvlExp;
        logic [1:0] xbarExp;
        logic [15:0] tmrSeen;
        xbarExp = regOneExp[3:2];
        tmrSeen = {8'h00, t0, t1, t2, t3};
        for (int i = 0; i < 7; i++) begin
            enExp[i] = |regTwoExp[2*i +: 2];
            lvlExp[2*i +: 2] = periphLvl(regTwoExp[2*i +: 2]);
        end
        checkVal("xbarPrio", 16'(xbarExp), 16'(xbarPrio));
        checkVal("xbarEn", 16'(|xbarExp), 16'(crossbarEnable));
        checkVal("xbarLvl", 16'(xbarExp), 16'(crossbarLevel));
        checkVal("limPrio", 16'(regTwoExp[13:12]), 16'(limPrio));
        checkVal("mainPrio", 16'(regTwoExp[11:10]), 16'(mainPrio));
        checkVal("bPrio", 16'(regTwoExp[9:8]), 16'(bPrio));
        checkVal("timers", {8'h00, regTwoExp[7:0]}, tmrSeen);
        checkVal("periphEn", 16'(enExp), 16'(periphEnable));
        checkVal("periphLvl", 16'(lvlExp), 16'(periphLevel));
    endtask

    // ************************************************
    // Clock, timeout and main sequence
    // ************************************************
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycleCount++;
        if (cycleCount == 2000) begin
            badCount++;
            summarize();
        end
    end

    initial begin
        reset = 1'h1;
        regOneExp = 16'h0000;
        regTwoExp = 16'h0000;
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        checkOutputs();
        m_core.readWord(`IPL_IDX_REG_TWO, got);
        checkVal("resetTwo", 16'h0000, got);
        foreach (rows[r]) begin
            m_core.writeWord(rows[r].addr, rows[r].wr);
            if (rows[r].addr == `IPL_IDX_REG_ONE) regOneExp = rows[r].rd;
            if (rows[r].addr == `IPL_IDX_REG_TWO) regTwoExp = rows[r].rd;
            // Read follows the write with no gap
            m_core.readWord(rows[r].addr, got);
            checkVal("readback", rows[r].rd, got);
            checkOutputs();
        end
        // Read data must fall back to zero after one cycle
        @(posedge clock);
        checkVal("readIdle", 16'h0000, readData);
        // Reset in mid-run clears both registers without a clock edge
        m_core.writeWord(`IPL_IDX_REG_TWO, 16'hFFFF);
        m_core.writeWord(`IPL_IDX_REG_ONE, 16'hFFFF);
        m_core.idle();
        regOneExp = `IPL_MASK_REG_ONE;
        regTwoExp = `IPL_MASK_REG_TWO;
        checkOutputs();
        #5;
        reset = 1'h1;
        regOneExp = 16'h0000;
        regTwoExp = 16'h0000;
        #1;
        checkOutputs();
        @(posedge clock);
        reset <= 1'h0;
        m_core.readWord(`IPL_IDX_REG_ONE, got);
        checkVal("rstOne", 16'h0000, got);
        m_core.readWord(`IPL_IDX_REG_TWO, got);
        checkVal("rstTwo", 16'h0000, got);
        summarize();
    end
endmodule
